/* src/channel_blocking_outputs.sv */
// Per-channel blocking outputs for one port: eight selection registers
// and the two gate pins they drive.
// Assumes the channel counters run on clk_sys and present a zero-based
// channel index that is stable for the whole time slot.
// Operating notes
// Each direction has its own slot position, so the two gates run from
// independent counters and may sit in different channels at any time.
// The gate is a flip-flop: it follows the channel index one clk_sys cycle
// late, which the far side must allow for when it gates its clock.
// The first valid cycle after the counter was idle always counts as a
// slot boundary, whatever channel index it carries, so a frame that
// starts at the top channel still gates correctly.
// A write that lands in the middle of a slot changes the stored bit at
// once but the gate only at the next boundary; this keeps a channel from
// being chopped into a partial clock burst.
// The line mode is sampled at every boundary; changing it while the
// counters run takes effect one slot later.
// Reads of unmapped addresses return zero and raise no error; writes to
// them are dropped.
// The register port is single-cycle: a strobe taken on an edge is done
// by the next edge, so back-to-back accesses need no wait states.
`timescale 1ns/10ps
`include "chan_block_defines.svh"

module channel_blocking_outputs #(
  parameter int NUM_REGS = 4
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Register port
  input  wire chan_block_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Line mode: 1 selects T1, 0 selects E1
  input  wire logic t1_mode,
  // Backplane channel positions
  input  wire chan_block_pkg::slot_pos_s rx_slot,
  input  wire chan_block_pkg::slot_pos_s tx_slot,
  // Gate outputs
  output logic rx_gate_out,
  output logic tx_gate_out
);

  // Selection storage, one byte per register index and direction
  logic [7:0] rx_sel_r [NUM_REGS];
  logic [7:0] tx_sel_r [NUM_REGS];
  // Flattened channel maps, bit c is zero-based channel c
  logic [31:0] rx_map;
  logic [31:0] tx_map;
  // Channels that exist in the current line mode, bit c for channel c
  logic [31:0] chan_live;
  // Address decode
  wire rx_set_hit;
  wire tx_set_hit;
  wire wr_rx;
  wire wr_tx;
  wire [1:0] reg_idx;
  // Register view under the names software uses
  wire [7:0] rx_block_sel_a;
  wire [7:0] rx_block_sel_b;
  wire [7:0] rx_block_sel_c;
  wire [7:0] rx_block_sel_d;
  wire [7:0] tx_block_sel_a;
  wire [7:0] tx_block_sel_b;
  wire [7:0] tx_block_sel_c;
  wire [7:0] tx_block_sel_d;
  // Read selection ahead of the read data flip-flops
  wire [7:0] rd_sel;
  // Gate state per direction
  logic rx_gate_r;
  logic tx_gate_r;
  logic rx_gate_nxt;
  logic tx_gate_nxt;
  logic [4:0] rx_chan_r;
  logic [4:0] tx_chan_r;
  logic rx_vld_r;
  logic tx_vld_r;
  wire rx_edge;
  wire tx_edge;
  wire rx_pick;
  wire tx_pick;
  wire [5:0] frame_chans;

  // Address decode: each set is four consecutive bytes
  assign rx_set_hit = (reg_req.addr & `BLOCK_SET_MASK) == `RX_BLOCK_SEL_A_ADDR;
  assign tx_set_hit = (reg_req.addr & `BLOCK_SET_MASK) == `TX_BLOCK_SEL_A_ADDR;
  assign reg_idx = reg_req.addr[1:0];
  assign reg_hit = rx_set_hit | tx_set_hit;
  // Unmapped writes fall through both strobes and are dropped
  assign wr_rx = reg_req.wr && rx_set_hit;
  assign wr_tx = reg_req.wr && tx_set_hit;

  // Selection registers, one generate entry per register index
  for (genvar k = 0; k < NUM_REGS; k++) begin : g_sel
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        rx_sel_r[k] <= `BLOCK_SEL_RESET;
        tx_sel_r[k] <= `BLOCK_SEL_RESET;
      end else if (reg_idx == 2'(k)) begin
        if (wr_rx) rx_sel_r[k] <= reg_req.wdata;
        if (wr_tx) tx_sel_r[k] <= reg_req.wdata;
      end
    end
    // Register k, bit n maps to zero-based channel 8*k+n
    assign rx_map[8*k +: 8] = rx_sel_r[k];
    assign tx_map[8*k +: 8] = tx_sel_r[k];
  end

  // Named register view; the fourth byte of each set holds channels 24 to 31
  assign rx_block_sel_a = rx_sel_r[0];
  assign rx_block_sel_b = rx_sel_r[1];
  assign rx_block_sel_c = rx_sel_r[2];
  assign rx_block_sel_d = rx_sel_r[3];
  assign tx_block_sel_a = tx_sel_r[0];
  assign tx_block_sel_b = tx_sel_r[1];
  assign tx_block_sel_c = tx_sel_r[2];
  assign tx_block_sel_d = tx_sel_r[3];

  // Read selection by full address; anything outside both sets reads zero
  assign rd_sel = (reg_req.addr == `RX_BLOCK_SEL_A_ADDR) ? rx_block_sel_a :
                  (reg_req.addr == `RX_BLOCK_SEL_B_ADDR) ? rx_block_sel_b :
                  (reg_req.addr == `RX_BLOCK_SEL_C_ADDR) ? rx_block_sel_c :
                  (reg_req.addr == `RX_BLOCK_SEL_D_ADDR) ? rx_block_sel_d :
                  (reg_req.addr == `TX_BLOCK_SEL_A_ADDR) ? tx_block_sel_a :
                  (reg_req.addr == `TX_BLOCK_SEL_B_ADDR) ? tx_block_sel_b :
                  (reg_req.addr == `TX_BLOCK_SEL_C_ADDR) ? tx_block_sel_c :
                  (reg_req.addr == `TX_BLOCK_SEL_D_ADDR) ? tx_block_sel_d :
                  8'h00;

  // Read data, registered so the data output comes from flip-flops
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= rd_sel;
    end
  end

  // Frame length per mode; channels at or past it never gate
  assign frame_chans = t1_mode ? `T1_CHANNELS : `E1_CHANNELS;

  // Per-channel existence mask; costs 32 comparators but keeps the gate path flat
  for (genvar c = 0; c < 32; c++) begin : g_live
    assign chan_live[c] = 6'(c) < frame_chans;
  end

  // Slot boundary: a new channel index, or the first valid cycle after idle
  assign rx_edge = rx_slot.valid && (!rx_vld_r || rx_slot.chan != rx_chan_r);
  assign tx_edge = tx_slot.valid && (!tx_vld_r || tx_slot.chan != tx_chan_r);

  // Level wanted for the current slot, each from its own direction's map only
  assign rx_pick = chan_live[rx_slot.chan] && rx_map[rx_slot.chan];
  assign tx_pick = chan_live[tx_slot.chan] && tx_map[tx_slot.chan];

  // Next receive gate level: low while idle, re-chosen only at a boundary
  always_comb begin
    rx_gate_nxt = rx_gate_r;
    if (!rx_slot.valid) begin
      rx_gate_nxt = 1'b0;
    end else if (rx_edge) begin
      rx_gate_nxt = rx_pick;
    end
  end

  // Next transmit gate level, same scheme on the transmit counter
  always_comb begin
    tx_gate_nxt = tx_gate_r;
    if (!tx_slot.valid) begin
      tx_gate_nxt = 1'b0;
    end else if (tx_edge) begin
      tx_gate_nxt = tx_pick;
    end
  end

  // Gate levels latch once per slot so a mid-slot write cannot chop a channel
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_gate_r <= 1'b0;
      tx_gate_r <= 1'b0;
      rx_chan_r <= 5'h1f;
      tx_chan_r <= 5'h1f;
      rx_vld_r <= 1'b0; // First valid cycle after reset is a boundary
      tx_vld_r <= 1'b0;
    end else begin
      rx_gate_r <= rx_gate_nxt;
      tx_gate_r <= tx_gate_nxt;
      rx_chan_r <= rx_slot.chan;
      tx_chan_r <= tx_slot.chan;
      rx_vld_r <= rx_slot.valid;
      tx_vld_r <= tx_slot.valid;
    end
  end

  // Pins straight from the gate flip-flops, free of decode glitches
  assign rx_gate_out = rx_gate_r;
  assign tx_gate_out = tx_gate_r;

endmodule : channel_blocking_outputs

/* src/chan_block_defines.svh */
// Constants for the per-channel blocking output generator.
// Assumes inclusion by bare name from the design module.
`ifndef CHAN_BLOCK_DEFINES_SVH
`define CHAN_BLOCK_DEFINES_SVH

// Register byte addresses on the parallel port
`define RX_BLOCK_SEL_A_ADDR 8'h88
`define RX_BLOCK_SEL_B_ADDR 8'h89
`define RX_BLOCK_SEL_C_ADDR 8'h8a
`define RX_BLOCK_SEL_D_ADDR 8'h8b
`define TX_BLOCK_SEL_A_ADDR 8'h8c
`define TX_BLOCK_SEL_B_ADDR 8'h8d
`define TX_BLOCK_SEL_C_ADDR 8'h8e
`define TX_BLOCK_SEL_D_ADDR 8'h8f
// Mask down to the base of each set, used for the set-hit decode
`define BLOCK_SET_MASK 8'hfc
// Reset value of every selection register
`define BLOCK_SEL_RESET 8'h00
// Channels per frame
`define T1_CHANNELS 6'h18
`define E1_CHANNELS 6'h20

`endif

/* src/chan_block_pkg.sv */
// Types for the per-channel blocking output generator.
// Assumes the defines header is compiled alongside.
package chan_block_pkg;

  // One register-port access, taken in a single clk_sys cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Channel position of one direction's backplane counter
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
  } slot_pos_s;

endpackage : chan_block_pkg

/* verif/cbo_checker.sv */
// Port checker for the blocking outputs.
// Assumes it is bound into the top module.
`timescale 1ns/10ps
module cbo_checker #(parameter int NUM_REGS = 4) (
  // Watched ports
  input wire logic clk_sys,
  input wire logic srst,
  input wire chan_block_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic t1_mode,
  input wire chan_block_pkg::slot_pos_s rx_slot,
  input wire chan_block_pkg::slot_pos_s tx_slot,
  input wire logic rx_gate_out,
  input wire logic tx_gate_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_RST: assert property (disable iff (1'b0) srst |=> !rx_gate_out && !tx_gate_out)
    else $error("gate after reset");
  AST_HIT: assert property (reg_hit == (reg_req.addr[7:3] == 5'h11)) else $error("hit");
  AST_UNMAP: assert property (reg_req.rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  AST_RBK: assert property (reg_req.wr && reg_hit ##1 reg_req.rd && $stable(reg_req.addr)
    |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("readback");
  AST_T1RX: assert property (t1_mode && rx_slot.chan > 5'h17 |=> !rx_gate_out)
    else $error("t1 rx");
  AST_T1TX: assert property (t1_mode && tx_slot.chan > 5'h17 |=> !tx_gate_out)
    else $error("t1 tx");
  AST_OFF: assert property (!rx_slot.valid |=> !rx_gate_out) else $error("idle gate");
  AST_HOLD: assert property (rx_slot.valid && $stable(rx_slot) && $stable(t1_mode)
    && !$past(srst) |=> $stable(rx_gate_out)) else $error("mid slot change");
endmodule : cbo_checker
bind channel_blocking_outputs cbo_checker #(.NUM_REGS(NUM_REGS)) u_chk (.*);

/* verif/slot_feeder.sv */
// Backplane slot counters for both directions, four cycles a slot.
// Assumes run and last change just after a clock edge.
`timescale 1ns/10ps
module slot_feeder (
  // Frame control
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [4:0] last,
  // Slot positions
  output chan_block_pkg::slot_pos_s rx_slot,
  output chan_block_pkg::slot_pos_s tx_slot
);
  logic [6:0] cnt_r = 7'h00;
  // Transmit counts down so the two gates see different bits
  always @(posedge clk_sys) cnt_r <= #1 (!run || cnt_r == {last, 2'h3}) ? 7'h00 : cnt_r + 7'h01;
  assign rx_slot = '{run, cnt_r[6:2]};
  assign tx_slot = '{run, last - cnt_r[6:2]};
endmodule : slot_feeder

/* verif/testbench.sv */
// Random and corner bench for the blocking outputs.
// Assumes package, design, feeder and checker are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: bad value", $time); end end
module testbench;
  logic clk_sys = 1'b0, srst = 1'b1, t1 = 1'b0, run = 1'b0, rx_gate_out, tx_gate_out;
  logic [4:0] last = 5'h1f;
  logic [7:0] rdata;
  logic [63:0] m = '0;
  chan_block_pkg::reg_req_s req = '0;
  chan_block_pkg::slot_pos_s rx_slot, tx_slot, rx_prev, tx_prev;
  int err_count = 0, compares = 0;
  channel_blocking_outputs u_dut (.clk_sys, .srst, .reg_req(req), .reg_rdata(rdata), .reg_hit(),
    .t1_mode(t1), .rx_slot, .tx_slot, .rx_gate_out, .tx_gate_out);
  slot_feeder u_feed (.clk_sys, .run, .last, .rx_slot, .tx_slot);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  function automatic logic exp_g(input logic [31:0] s, input chan_block_pkg::slot_pos_s p);
    return p.valid && s[p.chan] && !(t1 && p.chan > 5'h17);
  endfunction : exp_g
  // One access per cycle, held back to back; a read is checked against the model
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = (a[7:3] == 5'h11) ? m[8*a[2:0] +: 8] : 8'h00;
    if (w && a[7:3] == 5'h11) m[8*a[2:0] +: 8] = d;
    req = '{w, !w, a, d};
    @(posedge clk_sys);
    #1 if (!w) `CHK(rdata, e)
  endtask : acc
  // Gate follows the slot seen at the previous edge
  always @(posedge clk_sys) {rx_prev, tx_prev} <= {rx_slot, tx_slot};
  always @(negedge clk_sys) if (!srst) begin
    `CHK(rx_gate_out, exp_g(m[31:0], rx_prev))
    `CHK(tx_gate_out, exp_g(m[63:32], tx_prev))
  end
  initial begin
    void'($urandom(43));
    repeat (12) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int i = 0; i < 8; i++) acc(1'b0, 8'h88 + 8'(i), 8'h00);
    // Write and read back each byte, ones in each last byte, one unmapped
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 8'h88 + 8'(i), (i % 4 == 3) ? 8'hff : 8'($urandom));
      acc(1'b0, 8'h88 + 8'(i), 8'h00);
    end
    req = '0;
    $display("test registers done");
    // E1 frame, T1 frame, then T1 walking the unused slots
    for (int k = 0; k < 3; k++) begin
      {t1, last, run} = {k > 0, (k == 1) ? 5'h17 : 5'h1f, 1'b1};
      repeat (140) @(posedge clk_sys);
      #1 run = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 $display("test sweep %0d done", k);
    end
    report_and_stop();
  end
  // About 500 cycles are needed; twice that cuts a hang
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
endmodule : testbench
